/* File: bie_pkg.sv */
// shared constants, types and helpers for the branch and increment executor
package bie_pkg;
    localparam int INSTR_W = 12;
    localparam int DATA_W = 8;
    localparam int PC_W = 11;
    localparam int IMM_W = 9;
    localparam int FADDR_W = 5;
    localparam int STATUS_W = 8;

    localparam int JUMP_OP_HI = 11;
    localparam int JUMP_OP_LO = 9;
    localparam logic [2:0] JUMP_OPCODE = 3'h5;
    localparam int INC_OP_HI = 11;
    localparam int INC_OP_LO = 6;
    localparam logic [5:0] INC_OPCODE = 6'h0a;
    localparam logic [5:0] INCSZ_OPCODE = 6'h0f;
    localparam int DEST_BIT = 5;
    localparam int IMM_HI = 8;
    localparam int FADDR_HI = 4;

    localparam int PAGE_HI = 6;
    localparam int PAGE_LO = 5;

    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
    localparam logic [DATA_W-1:0] DATA_ONE = 8'h01;
    localparam logic [PC_W-1:0] PC_ZERO = 11'h000;
    localparam logic [FADDR_W-1:0] FADDR_ZERO = 5'h00;

    typedef enum logic [1:0] {
        BIE_EXEC = 2'b01,
        BIE_NOP = 2'b10
    } bie_state_e;

    function automatic logic [DATA_W-1:0] bie_inc(input logic [DATA_W-1:0] v);
        bie_inc = v + DATA_ONE;
    endfunction

    function automatic logic bie_is_zero(input logic [DATA_W-1:0] v);
        bie_is_zero = (v == DATA_ZERO);
    endfunction
endpackage

/* File: bie_dec_if.sv */
// decoded instruction fields passed from the decoder to the executor
`timescale 1ns/10ps
`default_nettype none
interface bie_dec_if;
    import bie_pkg::*;
    logic is_jump;
    logic is_inc;
    logic is_incsz;
    logic dest_file;
    logic [FADDR_W-1:0] faddr;
    logic [PC_W-1:0] jump_target;
    logic [DATA_W-1:0] inc_result;
    logic inc_zero;

    modport dec (
        output is_jump, is_inc, is_incsz, dest_file, faddr, jump_target, inc_result, inc_zero
    );
    modport exe (
        input is_jump, is_inc, is_incsz, dest_file, faddr, jump_target, inc_result, inc_zero
    );
endinterface
`default_nettype wire

/* File: bie_decode.sv */
// combinational decoder and incrementer for the three handled opcodes
`timescale 1ns/10ps
`default_nettype none
module bie_decode (
    input wire logic [bie_pkg::INSTR_W-1:0] i_instr,
    input wire logic [bie_pkg::DATA_W-1:0] i_file_data,
    input wire logic [bie_pkg::STATUS_W-1:0] i_status,
    bie_dec_if.dec dec
);
    import bie_pkg::*;

    wire logic [2:0] jump_field = i_instr[JUMP_OP_HI:JUMP_OP_LO];
    wire logic [5:0] inc_field = i_instr[INC_OP_HI:INC_OP_LO];
    wire logic [DATA_W-1:0] sum = bie_inc(i_file_data);

    assign dec.is_jump = (jump_field == JUMP_OPCODE);
    assign dec.is_inc = (inc_field == INC_OPCODE);
    assign dec.is_incsz = (inc_field == INCSZ_OPCODE);
    assign dec.dest_file = i_instr[DEST_BIT];
    assign dec.faddr = i_instr[FADDR_HI:0];
    // page bits of status on top, immediate below
    assign dec.jump_target = {i_status[PAGE_HI:PAGE_LO], i_instr[IMM_HI:0]};
    // plain 8-bit add, all ones wraps to zero
    assign dec.inc_result = sum;
    assign dec.inc_zero = bie_is_zero(sum);
endmodule
`default_nettype wire

/* File: bie_exec.sv */
// executor for jump_immediate, increment_register and increment_skip_on_zero
`timescale 1ns/10ps
`default_nettype none
module bie_exec (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_instr_valid,
    input wire logic [bie_pkg::INSTR_W-1:0] i_instr,
    input wire logic [bie_pkg::DATA_W-1:0] i_file_data,
    input wire logic [bie_pkg::STATUS_W-1:0] i_status,
    output logic o_pc_we,
    output logic [bie_pkg::PC_W-1:0] o_pc_value,
    output logic o_discard,
    output logic o_nop_slot,
    output logic o_w_we,
    output logic [bie_pkg::DATA_W-1:0] o_w_data,
    output logic o_f_we,
    output logic [bie_pkg::FADDR_W-1:0] o_f_addr,
    output logic [bie_pkg::DATA_W-1:0] o_f_data,
    output logic o_z_we,
    output logic o_z_value,
    output logic o_handled
);
    import bie_pkg::*;

    // ****************************************
    // decode
    // ****************************************
    bie_dec_if dec_bus ();

    bie_decode u_decode (
        .i_instr(i_instr),
        .i_file_data(i_file_data),
        .i_status(i_status),
        .dec(dec_bus)
    );

    // ****************************************
    // issue qualification
    // ****************************************
    bie_state_e state_q;
    bie_state_e state_d;

    // the word arriving during the nop slot was fetched before the redirect
    wire logic in_exec = (state_q == BIE_EXEC);
    wire logic issue = i_instr_valid && in_exec;
    wire logic do_jump = issue && dec_bus.is_jump;
    wire logic do_inc = issue && dec_bus.is_inc;
    wire logic do_incsz = issue && dec_bus.is_incsz;
    wire logic do_any_inc = do_inc || do_incsz;
    wire logic skip_now = do_incsz && dec_bus.inc_zero;
    wire logic need_nop = do_jump || skip_now;

    // ****************************************
    // cycle sequencing
    // ****************************************
    always_comb begin
        state_d = state_q;
        case (state_q)
            BIE_EXEC: begin
                if (need_nop) begin
                    state_d = BIE_NOP;
                end
            end
            BIE_NOP: begin
                state_d = BIE_EXEC;
            end
            default: begin
                state_d = BIE_EXEC;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_q <= BIE_EXEC;
        end else begin
            state_q <= state_d;
        end
    end

    // ****************************************
    // next values
    // ****************************************
    logic pc_we_d;
    logic [PC_W-1:0] pc_value_d;
    logic discard_d;
    logic nop_slot_d;
    logic w_we_d;
    logic f_we_d;
    logic z_we_d;
    logic handled_d;
    logic [FADDR_W-1:0] f_addr_d;
    logic [DATA_W-1:0] result_d;

    assign pc_we_d = do_jump;
    assign pc_value_d = do_jump ? dec_bus.jump_target : PC_ZERO;
    assign discard_d = need_nop;
    assign nop_slot_d = (state_q == BIE_NOP);
    assign w_we_d = do_any_inc && !dec_bus.dest_file;
    assign f_we_d = do_any_inc && dec_bus.dest_file;
    // only plain increment touches the zero flag; jump and skip leave it
    assign z_we_d = do_inc;
    assign handled_d = do_jump || do_any_inc;
    assign f_addr_d = do_any_inc ? dec_bus.faddr : FADDR_ZERO;
    assign result_d = do_any_inc ? dec_bus.inc_result : DATA_ZERO;

    // ****************************************
    // program counter and pipeline control
    // ****************************************
    logic pc_we_q;
    logic [PC_W-1:0] pc_value_q;
    logic discard_q;
    logic nop_slot_q;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            pc_we_q <= 1'b0;
            pc_value_q <= PC_ZERO;
        end else begin
            pc_we_q <= pc_we_d;
            pc_value_q <= pc_value_d;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            discard_q <= 1'b0;
            nop_slot_q <= 1'b0;
        end else begin
            discard_q <= discard_d;
            nop_slot_q <= nop_slot_d;
        end
    end

    // ****************************************
    // accumulator and file register writes
    // ****************************************
    logic w_we_q;
    logic [DATA_W-1:0] w_data_q;
    logic f_we_q;
    logic [FADDR_W-1:0] f_addr_q;
    logic [DATA_W-1:0] f_data_q;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            w_we_q <= 1'b0;
            w_data_q <= DATA_ZERO;
        end else begin
            w_we_q <= w_we_d;
            w_data_q <= result_d;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            f_we_q <= 1'b0;
            f_addr_q <= FADDR_ZERO;
            f_data_q <= DATA_ZERO;
        end else begin
            f_we_q <= f_we_d;
            f_addr_q <= f_addr_d;
            f_data_q <= result_d;
        end
    end

    // ****************************************
    // zero flag and handled
    // ****************************************
    logic z_we_q;
    logic z_value_q;
    logic handled_q;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            z_we_q <= 1'b0;
            z_value_q <= 1'b0;
        end else begin
            z_we_q <= z_we_d;
            z_value_q <= do_inc && dec_bus.inc_zero;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            handled_q <= 1'b0;
        end else begin
            handled_q <= handled_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign o_pc_we = pc_we_q;
    assign o_pc_value = pc_value_q;
    assign o_discard = discard_q;
    assign o_nop_slot = nop_slot_q;
    assign o_w_we = w_we_q;
    assign o_w_data = w_data_q;
    assign o_f_we = f_we_q;
    assign o_f_addr = f_addr_q;
    assign o_f_data = f_data_q;
    assign o_z_we = z_we_q;
    assign o_z_value = z_value_q;
    assign o_handled = handled_q;
endmodule
`default_nettype wire

/* File: bie_exec_asserts.sv */
// assertions on the executor ports
`timescale 1ns/10ps
`default_nettype none
module bie_exec_asserts import bie_pkg::*; (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_instr_valid,
    input wire logic [INSTR_W-1:0] i_instr,
    input wire logic [DATA_W-1:0] i_file_data,
    input wire logic [STATUS_W-1:0] i_status,
    input wire logic o_pc_we,
    input wire logic [PC_W-1:0] o_pc_value,
    input wire logic o_discard,
    input wire logic o_nop_slot,
    input wire logic o_w_we,
    input wire logic [DATA_W-1:0] o_w_data,
    input wire logic o_f_we,
    input wire logic [FADDR_W-1:0] o_f_addr,
    input wire logic [DATA_W-1:0] o_f_data,
    input wire logic o_z_we,
    input wire logic o_z_value,
    input wire logic o_handled
);
    // ****
    // taken words
    // ****
    // a raised discard marks the nop slot, so nothing is taken there
    wire tk = i_instr_valid && !o_discard;
    wire jmp = tk && i_instr[11:9] == JUMP_OPCODE;
    wire inc = tk && i_instr[11:6] == INC_OPCODE;
    wire isz = tk && i_instr[11:6] == INCSZ_OPCODE;
    wire ff = i_file_data == 8'hff;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    a_jump_target: assert property (jmp |=> o_pc_we && o_discard && !o_z_we &&
        o_pc_value == {$past(i_status[6:5]), $past(i_instr[8:0])}) else $error("jump");
    a_jump_slot: assert property (o_pc_we |=> o_nop_slot && !o_handled)
        else $error("slot");
    a_inc_zflag: assert property (inc |=> o_z_we && o_z_value == $past(ff))
        else $error("zflag");
    a_dest_acc: assert property ((inc || isz) && !i_instr[5] |=> o_w_we && !o_f_we &&
        o_w_data == $past(i_file_data) + 8'h01) else $error("to acc");
    a_dest_file: assert property ((inc || isz) && i_instr[5] |=> o_f_we && !o_w_we &&
        o_f_addr == $past(i_instr[4:0]) && o_f_data == $past(i_file_data) + 8'h01)
        else $error("to file");
    a_skip_zero: assert property (isz |=> !o_z_we && o_discard == $past(ff))
        else $error("skip");
    a_wrap_zero: assert property ((inc || isz) && ff |=> (o_w_data | o_f_data) == 8'h00)
        else $error("wrap");
endmodule
bind bie_exec bie_exec_asserts i_bie_exec_asserts (.*);
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the executor
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import bie_pkg::*;
    // ****
    // signals
    // ****
    localparam logic [39:0] NOPV = 40'h0004000000;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic i_instr_valid = 1'b0;
    logic [INSTR_W-1:0] i_instr = 12'h000;
    logic [DATA_W-1:0] i_file_data = 8'h00;
    logic [STATUS_W-1:0] i_status = 8'h00;
    logic o_pc_we, o_discard, o_nop_slot, o_w_we, o_f_we, o_z_we, o_z_value, o_handled;
    logic [PC_W-1:0] o_pc_value;
    logic [DATA_W-1:0] o_w_data, o_f_data;
    logic [FADDR_W-1:0] o_f_addr;
    logic [39:0] q[$];
    logic [11:0] ins;
    logic [31:0] r;
    int errors = 0;
    int compares = 0;
    int seed = 32'h4a0d;
    // data fields are masked by their enables, their idle value is left open
    wire [39:0] got = {o_pc_we, o_pc_we ? o_pc_value : 11'h000, o_discard, o_nop_slot,
        o_w_we, o_w_we ? o_w_data : 8'h00, o_f_we, o_f_we ? o_f_addr : 5'h00,
        o_f_we ? o_f_data : 8'h00, o_z_we, o_z_we & o_z_value, o_handled};
    always #4 i_clk = ~i_clk;
    bie_exec i_bie_exec (.*);
    // ****
    // tasks
    // ****
    function automatic logic [39:0] model(input logic [11:0] a, input logic [7:0] fd,
        input logic [7:0] st);
        logic [7:0] s;
        logic j, n, k, w, f;
        s = fd + 8'h01;
        j = a[11:9] == 3'h5;
        n = a[11:6] == 6'h0a;
        k = a[11:6] == 6'h0f;
        w = (n | k) & !a[5];
        f = (n | k) & a[5];
        return {j, j ? {st[6:5], a[8:0]} : 11'h000, j | (k & s == 8'h00), 1'b0, w,
            w ? s : 8'h00, f, f ? a[4:0] : 5'h00, f ? s : 8'h00, n, n & s == 8'h00, j | n | k};
    endfunction
    task automatic cmp(input logic [39:0] e, input logic [39:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic go(input logic [11:0] a, input logic [7:0] fd, input logic [7:0] st,
        input logic v);
        logic [39:0] e;
        @(negedge i_clk);
        i_instr_valid = v;
        i_instr = a;
        i_file_data = fd;
        i_status = st;
        e = model(a, fd, st);
        if (v && e !== 40'h0) q.push_back(e);
        if (v && e[27]) begin
            q.push_back(NOPV);
            @(negedge i_clk);
            // a jump in the slot must be ignored
            i_instr = 12'hbff;
        end
    endtask
    task automatic rst();
        @(negedge i_clk);
        i_reset = 1'b1;
        i_instr_valid = 1'b0;
        q.delete();
        repeat (6) @(negedge i_clk);
        i_reset = 1'b0;
    endtask
    task automatic print_verdict();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ****
    // checking and sequence
    // ****
    always @(negedge i_clk) begin
        if (!i_reset && got !== 40'h0) cmp(q.size() > 0 ? q.pop_front() : 40'h0, got);
    end
    initial begin
        #80000;
        errors++;
        print_verdict();
    end
    initial begin
        rst();
        go(12'h2b3, 8'hff, 8'h00, 1'b1);
        go(12'h284, 8'h41, 8'h00, 1'b1);
        go(12'h3df, 8'hff, 8'h00, 1'b1);
        go(12'h3e2, 8'h7e, 8'h00, 1'b1);
        go(12'hbff, 8'h00, 8'h60, 1'b1);
        go(12'ha00, 8'h00, 8'h9f, 1'b1);
        $display("directed test done");
        repeat (400) begin
            r = $random(seed);
            ins = r[13:12] == 2'd0 ? {3'h5, r[8:0]} : r[13:12] == 2'd1 ? {6'h0a, r[5:0]} :
                r[13:12] == 2'd2 ? {6'h0f, r[5:0]} : {3'h0, r[8:0]};
            go(ins, r[15:14] == 2'd0 ? 8'hff : r[23:16], r[31:24], r[11:10] != 2'd0);
        end
        $display("random test done");
        repeat (2) go(12'h000, 8'h00, 8'h00, 1'b0);
        // every noted result must have shown up before reset wipes the queue
        cmp(40'(q.size()), 40'h0);
        rst();
        go(12'hb55, 8'h00, 8'h20, 1'b1);
        repeat (3) go(12'h000, 8'h00, 8'h00, 1'b0);
        cmp(40'(q.size()), 40'h0);
        $display("reset test done");
        print_verdict();
    end
endmodule
`default_nettype wire
